/* File: fault_status_register_bank.sv */
`timescale 1ns/1ps
`include "fault_status_map.svh"
module fault_status_register_bank
    import fault_status_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic PAGE,
    input wire logic RD_STROBE,
    input wire logic [7:0] CMD,
    input wire logic [15:0] VOUT_EVT,
    input wire logic [15:0] IOUT_EVT,
    input wire logic [7:0] INPUT_EVT,
    input wire logic [7:0] TEMP_EVT,
    input wire logic [1:0] VOUT_CLR,
    input wire logic [1:0] IOUT_CLR,
    input wire logic INPUT_CLR,
    input wire logic TEMP_CLR,
    input wire logic VIN_ABOVE_UV,
    input wire logic POWER_GOOD_N,
    input wire logic OUTPUT_OFF,
    input wire logic VENDOR_EVENT_FLAG,
    input wire logic COMM_MEMORY_LOGIC_FLAG,
    input wire logic OTHER_CHANGE,
    output logic [15:0] RD_DATA,
    output logic RD_VALID,
    output logic RD_ERROR
);
    page_detail_if pd ();
    detail_t input_r, temp_r;
    logic uv_armed_r;
    logic pg_meta_r, pg_sync_r, off_meta_r, off_sync_r;
    logic vin_meta_r, vin_sync_r;
    word_t summary, rd_nxt;
    logic err_nxt;

    page_detail u_pages (
        .clk(CLK_SYS),
        .rst(RESET),
        .vout_evt(VOUT_EVT),
        .iout_evt(IOUT_EVT),
        .vout_clr(VOUT_CLR),
        .iout_clr(IOUT_CLR),
        .page(PAGE),
        .pd(pd)
    );

    // Analog-side levels may change asynchronously to the core clock
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            pg_meta_r <= 1'b0;
            pg_sync_r <= 1'b0;
            off_meta_r <= 1'b1;
            off_sync_r <= 1'b1;
            vin_meta_r <= 1'b0;
            vin_sync_r <= 1'b0;
        end else begin
            pg_meta_r <= POWER_GOOD_N;
            pg_sync_r <= pg_meta_r;
            off_meta_r <= OUTPUT_OFF;
            off_sync_r <= off_meta_r;
            vin_meta_r <= VIN_ABOVE_UV;
            vin_sync_r <= vin_meta_r;
        end
    end

    // Undervoltage is meaningless before the input has ever come up
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            uv_armed_r <= 1'b0;
        end else if (vin_sync_r) begin
            uv_armed_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            input_r <= `ZERO8;
        end else begin
            input_r <= ((INPUT_CLR ? `ZERO8 : input_r)
                       | (INPUT_EVT & {3'h7, uv_armed_r, 4'hf}))
                       & `INPUT_USED_MASK;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            temp_r <= `ZERO8;
        end else begin
            temp_r <= ((TEMP_CLR ? `ZERO8 : temp_r) | TEMP_EVT) & `TEMP_USED_MASK;
        end
    end

    always_comb begin
        summary = `ZERO16;
        summary[`SUM_VOUT_BIT] = pd.any_vout;
        summary[`SUM_IOUT_BIT] = pd.any_iout;
        summary[`SUM_INPUT_BIT] = |input_r;
        summary[`SUM_VENDOR_BIT] = VENDOR_EVENT_FLAG;
        summary[`SUM_PGOOD_BIT] = pg_sync_r;
        summary[`SUM_OFF_BIT] = off_sync_r;
        summary[`SUM_OV_BIT] = pd.any_ov;
        summary[`SUM_OC_BIT] = pd.any_oc;
        summary[`SUM_UV_BIT] = input_r[`INPUT_UV_BIT];
        summary[`SUM_TEMP_BIT] = |temp_r;
        summary[`SUM_CML_BIT] = COMM_MEMORY_LOGIC_FLAG;
        summary[`SUM_OTHER_BIT] = OTHER_CHANGE;
    end

    always_comb begin
        rd_nxt = `ZERO16;
        err_nxt = 1'b0;
        if (CMD == `CMD_BYTE) begin
            rd_nxt = {8'h00, summary[7:0]};
        end else if (CMD == `CMD_WORD) begin
            rd_nxt = summary;
        end else if (CMD == `CMD_VOUT) begin
            rd_nxt = {8'h00, pd.vout};
        end else if (CMD == `CMD_IOUT) begin
            rd_nxt = {8'h00, pd.iout};
        end else if (CMD == `CMD_INPUT) begin
            rd_nxt = {8'h00, input_r};
        end else if (CMD == `CMD_TEMP) begin
            rd_nxt = {8'h00, temp_r};
        end else begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            RD_DATA <= `ZERO16;
            RD_VALID <= 1'b0;
            RD_ERROR <= 1'b0;
        end else begin
            RD_VALID <= RD_STROBE;
            RD_ERROR <= RD_STROBE & err_nxt;
            if (RD_STROBE) begin
                RD_DATA <= rd_nxt;
            end
        end
    end
endmodule

/* File: fault_status_map.svh */
`ifndef FAULT_STATUS_MAP_SVH
`define FAULT_STATUS_MAP_SVH

`define CMD_BYTE 8'h78
`define CMD_WORD 8'h79
`define CMD_VOUT 8'h7a
`define CMD_IOUT 8'h7b
`define CMD_INPUT 8'h7c
`define CMD_TEMP 8'h7d
`define NUM_PAGES 2
`define VOUT_USED_MASK 8'h98
`define IOUT_USED_MASK 8'hc8
`define INPUT_USED_MASK 8'h94
`define TEMP_USED_MASK 8'hd0
`define VOUT_OV_BIT 7
`define VOUT_UV_BIT 4
`define VOUT_MAX_BIT 3
`define IOUT_OC_BIT 7
`define IOUT_OCUV_BIT 6
`define IOUT_SHARE_BIT 3
`define INPUT_OV_BIT 7
`define INPUT_UV_BIT 4
`define INPUT_OC_BIT 2
`define TEMP_OT_BIT 7
`define TEMP_OTW_BIT 6
`define TEMP_UT_BIT 4
`define SUM_VOUT_BIT 15
`define SUM_IOUT_BIT 14
`define SUM_INPUT_BIT 13
`define SUM_VENDOR_BIT 12
`define SUM_PGOOD_BIT 11
`define SUM_OFF_BIT 6
`define SUM_OV_BIT 5
`define SUM_OC_BIT 4
`define SUM_UV_BIT 3
`define SUM_TEMP_BIT 2
`define SUM_CML_BIT 1
`define SUM_OTHER_BIT 0
`define ZERO8 8'h00
`define ZERO16 16'h0000
`endif

/* File: fault_status_pkg.sv */
package fault_status_pkg;
    typedef logic [7:0] detail_t;
    typedef logic [15:0] word_t;
    typedef logic [7:0] cmd_t;
endpackage

/* File: page_detail_if.sv */
`timescale 1ns/1ps
interface page_detail_if;
    import fault_status_pkg::*;
    detail_t vout;
    detail_t iout;
    logic any_vout;
    logic any_iout;
    logic any_ov;
    logic any_oc;
    modport store (output vout, iout, any_vout, any_iout, any_ov, any_oc);
    modport user (input vout, iout, any_vout, any_iout, any_ov, any_oc);
endinterface

/* File: page_detail.sv */
`timescale 1ns/1ps
`include "fault_status_map.svh"
module page_detail
    import fault_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [`NUM_PAGES*8-1:0] vout_evt,
    input wire logic [`NUM_PAGES*8-1:0] iout_evt,
    input wire logic [`NUM_PAGES-1:0] vout_clr,
    input wire logic [`NUM_PAGES-1:0] iout_clr,
    input wire logic page,
    page_detail_if.store pd
);
    detail_t vout_r [`NUM_PAGES];
    detail_t iout_r [`NUM_PAGES];
    logic [`NUM_PAGES-1:0] v_any, i_any, v_ov, i_oc;

    genvar g;
    generate
        for (g = 0; g < `NUM_PAGES; g++) begin : pg
            // Set beats clear so an event in the clearing cycle survives
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    vout_r[g] <= `ZERO8;
                end else begin
                    vout_r[g] <= ((vout_clr[g] ? `ZERO8 : vout_r[g])
                                 | vout_evt[g*8 +: 8]) & `VOUT_USED_MASK;
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    iout_r[g] <= `ZERO8;
                end else begin
                    iout_r[g] <= ((iout_clr[g] ? `ZERO8 : iout_r[g])
                                 | iout_evt[g*8 +: 8]) & `IOUT_USED_MASK;
                end
            end
            assign v_any[g] = |vout_r[g];
            assign i_any[g] = |iout_r[g];
            assign v_ov[g] = vout_r[g][`VOUT_OV_BIT];
            assign i_oc[g] = iout_r[g][`IOUT_OC_BIT];
        end
    endgenerate

    assign pd.vout = vout_r[page];
    assign pd.iout = iout_r[page];
    assign pd.any_vout = |v_any;
    assign pd.any_iout = |i_any;
    assign pd.any_ov = |v_ov;
    assign pd.any_oc = |i_oc;
endmodule

/* File: fault_status_sva.sv */
`timescale 1ns/1ps
module fault_status_sva (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic RD_STROBE,
    input wire logic [7:0] CMD,
    input wire logic [15:0] VOUT_EVT,
    input wire logic [7:0] TEMP_EVT,
    input wire logic VENDOR_EVENT_FLAG,
    input wire logic COMM_MEMORY_LOGIC_FLAG,
    input wire logic OTHER_CHANGE,
    input wire logic [15:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic RD_ERROR
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    a_answer_follows: assert property (RD_STROBE |=> RD_VALID) else $error("no answer");
    a_answer_cause: assert property (RD_VALID |-> $past(RD_STROBE)) else $error("stray answer");
    a_unknown_cmd: assert property (RD_STROBE && !(CMD inside {[8'h78:8'h7d]})
        |=> RD_ERROR && RD_DATA == 16'h0000) else $error("unknown code not refused");
    a_word_unused: assert property (RD_STROBE && CMD == 8'h79 |=> RD_DATA[10:7] == 4'h0)
        else $error("summary unused bits set");
    a_byte_upper: assert property (RD_STROBE && CMD inside {8'h78, [8'h7a:8'h7d]}
        |=> RD_DATA[15:8] == 8'h00 && !RD_ERROR) else $error("byte read upper bits");
    a_live_bits: assert property (RD_STROBE && CMD == 8'h79
        && $stable({VENDOR_EVENT_FLAG, COMM_MEMORY_LOGIC_FLAG, OTHER_CHANGE})
        |=> {RD_DATA[12], RD_DATA[1:0]}
        == $past({VENDOR_EVENT_FLAG, COMM_MEMORY_LOGIC_FLAG, OTHER_CHANGE}))
        else $error("live summary bits");
    a_data_holds: assert property (!$past(RD_STROBE) |-> $stable(RD_DATA)) else $error("data moved");
    a_vout_summary: assert property (VOUT_EVT[7] ##1 (RD_STROBE && CMD == 8'h79)
        |=> RD_DATA[15] && RD_DATA[5]) else $error("overvoltage summary");
    a_temp_summary: assert property ((|TEMP_EVT[7:6]) ##1 (RD_STROBE && CMD == 8'h79)
        |=> RD_DATA[2]) else $error("temperature summary");
endmodule
bind fault_status_register_bank fault_status_sva u_sva (.CLK_SYS, .RESET, .RD_STROBE, .CMD,
    .VOUT_EVT, .TEMP_EVT, .VENDOR_EVENT_FLAG, .COMM_MEMORY_LOGIC_FLAG, .OTHER_CHANGE,
    .RD_DATA, .RD_VALID, .RD_ERROR);

/* File: host_reader.sv */
`timescale 1ns/1ps
module host_reader
    import fault_status_pkg::*;
(
    input wire logic clk,
    input wire word_t rd_data,
    input wire logic rd_error,
    input wire logic rd_valid,
    output cmd_t cmd,
    output logic rd_strobe,
    output logic page
);
    word_t data;
    logic err;
    logic valid;
    initial begin
        {rd_strobe, cmd, page} = '0;
    end
    task automatic read(input cmd_t c, input logic p);
        @(negedge clk);
        {rd_strobe, cmd, page} = {1'b1, c, p};
        @(negedge clk);
        // Valid and error stand for one cycle only, so take them before release
        data = rd_data;
        err = rd_error;
        valid = rd_valid;
        // Released lines show other values so a late sample cannot pass
        {rd_strobe, cmd, page} = {1'b0, ~c, ~p};
    endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import fault_status_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strobe, page, valid, rd_err, vin_ok, pg_n, off, vend, comm_memory_logic_flag, oth, iclr, tclr;
    cmd_t cmd;
    word_t data, vout, iout;
    detail_t inp, temp;
    logic [1:0] vclr, oclr;
    int err_count = 0;
    int total_checks = 0;
    always #25 clk = ~clk;
    fault_status_register_bank u_dut (.CLK_SYS(clk), .RESET(rst), .PAGE(page),
        .RD_STROBE(strobe), .CMD(cmd), .VOUT_EVT(vout), .IOUT_EVT(iout), .INPUT_EVT(inp),
        .TEMP_EVT(temp), .VOUT_CLR(vclr), .IOUT_CLR(oclr), .INPUT_CLR(iclr), .TEMP_CLR(tclr),
        .VIN_ABOVE_UV(vin_ok), .POWER_GOOD_N(pg_n), .OUTPUT_OFF(off), .VENDOR_EVENT_FLAG(vend),
        .COMM_MEMORY_LOGIC_FLAG(comm_memory_logic_flag), .OTHER_CHANGE(oth), .RD_DATA(data), .RD_VALID(valid),
        .RD_ERROR(rd_err));
    host_reader u_host (.clk(clk), .rd_data(data), .rd_error(rd_err), .rd_valid(valid),
        .cmd(cmd), .rd_strobe(strobe), .page(page));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_data(input string what, input word_t exp, input word_t got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_flag(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic read_chk(input cmd_t c, input logic p, input word_t exp);
        u_host.read(c, p);
        chk_data($sformatf("code %h", c), exp, u_host.data);
        chk_flag("valid", 1'b1, u_host.valid);
        chk_flag("error", !(c inside {[8'h78:8'h7d]}), u_host.err);
    endtask
    task automatic evt(input word_t v, input word_t i, input detail_t n, input detail_t t,
                       input cmd_t c, input logic p, input detail_t d, input word_t w);
        @(negedge clk);
        {vout, iout, inp, temp} = {v, i, n, t};
        fork
            u_host.read(8'h79, ~p);
            begin
                @(negedge clk);
                {vout, iout, inp, temp} = '0;
            end
        join
        chk_data("summary", w, u_host.data);
        read_chk(8'h78, p, {8'h00, w[7:0]});
        read_chk(c, p, {8'h00, d});
        if (c < 8'h7c) read_chk(c, ~p, 16'h0000);
        @(negedge clk);
        {vclr, oclr, iclr, tclr} = 6'h3f;
        @(negedge clk);
        {vclr, oclr, iclr, tclr} = 6'h00;
        read_chk(8'h79, p, 16'h0000);
    endtask
    initial begin
        {vout, iout, inp, temp, vclr, oclr, iclr, tclr, vin_ok, vend, comm_memory_logic_flag, oth} = '0;
        {pg_n, off} = 2'b11;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        read_chk(8'h79, 1'b0, 16'h0840);
        read_chk(8'h78, 1'b0, 16'h0040);
        {pg_n, off} = 2'b00;
        repeat (3) @(negedge clk);
        read_chk(8'h79, 1'b1, 16'h0000);
        $display("reset test done");
        evt(16'h0080, 0, 0, 0, 8'h7a, 1'b0, 8'h80, 16'h8020);
        evt(16'hff00, 0, 0, 0, 8'h7a, 1'b1, 8'h98, 16'h8020);
        evt(0, 16'h0800, 0, 0, 8'h7b, 1'b1, 8'h08, 16'h4000);
        evt(0, 16'h00ff, 0, 0, 8'h7b, 1'b0, 8'hc8, 16'h4010);
        evt(0, 0, 8'hff, 0, 8'h7c, 1'b0, 8'h84, 16'h2000);
        vin_ok = 1'b1;
        repeat (3) @(negedge clk);
        evt(0, 0, 8'h10, 0, 8'h7c, 1'b1, 8'h10, 16'h2008);
        evt(0, 0, 0, 8'hff, 8'h7d, 1'b0, 8'hd0, 16'h0004);
        evt(0, 0, 0, 8'h40, 8'h7d, 1'b1, 8'h40, 16'h0004);
        $display("event test done");
        {vend, comm_memory_logic_flag, oth, pg_n, off} = 5'h1f;
        repeat (3) @(negedge clk);
        read_chk(8'h79, 1'b0, 16'h1843);
        read_chk(8'h78, 1'b1, 16'h0043);
        read_chk(8'h7e, 1'b0, 16'h0000);
        read_chk(8'h77, 1'b0, 16'h0000);
        $display("live and error test done");
        complete_run();
    end
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule
